// ===== src/display_memory_interface.sv
// Purpose: arbitrated access to the shared display/auxiliary memory
// Assumes: all inputs synchronous to i_clk; display and capture
//          address the display area by byte offset
// Notes:   memory is not reset; only display block 0 is refilled
//
// Contract
// - one controller serves capture, display, microcontroller
// - aux area decoded at 0000H to 02FFH
// - display at 2000H and 8000H, same bytes
// - aux and 8000H range via data moves only
// - 2000H-23FFH via moves or indirect port
// - display area usable as extra aux
// - aux never initialised, contents kept
// - power-up fills display block zero with 20H
// - reset refills display; idle exit keeps
// - row, column pointers and data register
// - data access advances pointers afterwards
// - column wraps after 39, row increments
// - row 25 column 23 wraps to zero
// - offset plus block base gives address
// - offset row*32+col, wide columns folded
// - reset clears text page, flag set
// - clear-memory bit requests clear, not stored
// - one page per line, capture first
// - flag set on request, cleared when done
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module display_memory_interface
  import display_memory_pkg::*;
(
  // clock and reset
  input  wire  logic        i_clk,
  input  wire  logic        i_sys_rst,
  // register port
  input  wire  logic [3:0]  i_reg_addr,
  input  wire  logic [7:0]  i_reg_wdata,
  input  wire  logic        i_reg_wr,
  input  wire  logic        i_reg_rd,
  output var   logic [7:0]  o_reg_rdata,
  // external data move port
  input  wire  logic [15:0] i_xd_addr,
  input  wire  logic [7:0]  i_xd_wdata,
  input  wire  logic        i_xd_wr,
  input  wire  logic        i_xd_rd,
  output logic              o_xd_wait,
  output var   logic [7:0]  o_xd_rdata,
  output var   logic        o_xd_rvalid,
  // display read port
  input  wire  logic        i_disp_rd,
  input  wire  logic [10:0] i_disp_addr,
  output var   logic [7:0]  o_disp_data,
  output var   logic        o_disp_valid,
  // capture write port and line timing
  input  wire  logic        i_cap_wr,
  input  wire  logic [10:0] i_cap_addr,
  input  wire  logic [7:0]  i_cap_wdata,
  input  wire  logic        i_cap_force_clear,
  input  wire  logic        i_line_start,
  // status
  output var   logic        o_page_clearing,
  output var   logic        o_refresh
);

  // text position to 10-bit offset
  function automatic logic [9:0] rc_offset(input logic [4:0] row,
                                           input logic [5:0] col);
    logic [9:0] r10;
    logic [9:0] c10;
    r10 = {5'd0, row};
    c10 = {4'd0, col};
    if (col < WIDE_COL) begin
      rc_offset = (r10 << 5) + c10;
    end else begin
      rc_offset = WIDE_BASE - (r10 << 3) + (c10 - 10'd32);
    end
  endfunction

  // display offset to physical index
  function automatic logic [10:0] disp_phys(input logic [10:0] ofs);
    disp_phys = DISP_PHYS_BASE + ofs;
  endfunction

  // no reset: aux bytes start unknown and keep contents
  logic [7:0]  mem_r [0:MEM_BYTES-1];
  logic [4:0]  row_r;
  logic [5:0]  col_r;
  clr_state_e  clr_state_r;
  logic [9:0]  clr_idx_r;
  logic [11:0] refresh_cnt_r;

  // external data move address decode
  logic        xd_hit;
  logic [10:0] xd_phys;
  logic [15:0] xd_rel;
  always_comb begin
    xd_hit  = 1'b0;
    xd_phys = 11'd0;
    xd_rel  = 16'd0;
    if (i_xd_addr <= AUX_HI) begin
      xd_hit  = 1'b1;
      xd_phys = AUX_PHYS_BASE + i_xd_addr[10:0];
    end else if (i_xd_addr >= TEXT_LO && i_xd_addr <= TEXT_HI) begin
      xd_rel  = i_xd_addr - TEXT_LO;
      xd_hit  = 1'b1;
      xd_phys = disp_phys(xd_rel[10:0]);
    end else if (i_xd_addr >= CAPT_LO && i_xd_addr <= CAPT_HI) begin
      xd_rel  = i_xd_addr - CAPT_LO;
      xd_hit  = 1'b1;
      xd_phys = disp_phys(xd_rel[10:0]);
    end
  end

  // indirect port decode
  logic       ind_wr;
  logic       ind_rd;
  logic       ind_acc;
  logic       ctl_wr;
  logic [10:0] ind_phys;
  assign ind_wr   = i_reg_wr && (i_reg_addr == IND_DATA_OFS);
  assign ind_rd   = i_reg_rd && (i_reg_addr == IND_DATA_OFS);
  assign ind_acc  = ind_wr || ind_rd;
  assign ctl_wr   = i_reg_wr && (i_reg_addr == ROW_PTR_OFS);
  assign ind_phys = disp_phys({1'b0, rc_offset(row_r, col_r)});

  // refresh slot
  logic refresh_slot;
  assign refresh_slot = (refresh_cnt_r == 12'(REFRESH_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      refresh_cnt_r <= 12'd0;
    end else if (refresh_slot) begin
      refresh_cnt_r <= 12'd0;
    end else begin
      refresh_cnt_r <= refresh_cnt_r + 12'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_refresh <= 1'b0;
    end else begin
      o_refresh <= refresh_slot;
    end
  end

  // page clear sequencing
  logic clr_active;
  logic clr_write;
  logic clr_last;
  logic clr_req;
  assign clr_req    = ctl_wr && i_reg_wdata[CLEAR_MEM_BIT];
  assign clr_active = (clr_state_r == CLR_RUN);
  // clear yields to indirect and capture writes and to refresh; moves wait for it
  assign clr_write  = clr_active && !ind_wr && !i_cap_wr && !refresh_slot;
  assign clr_last   = clr_write && (clr_idx_r == 10'(PAGE_BYTES - 1));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clr_state_r <= CLR_RUN;
    end else begin
      case (clr_state_r)
        CLR_IDLE: begin
          if (clr_req) begin
            clr_state_r <= CLR_WAIT_LINE;
          end
        end
        CLR_WAIT_LINE: begin
          if (i_line_start && !i_cap_force_clear) begin
            clr_state_r <= CLR_RUN;
          end
        end
        CLR_RUN: begin
          if (clr_last) begin
            // a request landing on the last write is kept
            clr_state_r <= clr_req ? CLR_WAIT_LINE : CLR_IDLE;
          end
        end
        default: begin
          clr_state_r <= CLR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      clr_idx_r <= CLR_IDX_RST;
    end else if (clr_write) begin
      clr_idx_r <= clr_last ? CLR_IDX_RST : clr_idx_r + 10'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_page_clearing <= 1'b1;
    end else begin
      o_page_clearing <= (clr_state_r != CLR_IDLE && !clr_last) || clr_req
                         || (clr_last && clr_req);
    end
  end

  // micro moves wait for every other user
  logic xd_req;
  logic xd_grant;
  assign xd_req    = i_xd_rd || i_xd_wr;
  assign o_xd_wait = xd_req && (i_disp_rd || refresh_slot || ind_acc
                     || i_cap_wr || clr_active);
  assign xd_grant  = xd_req && !o_xd_wait;

  // memory write port; one write per cycle, indirect before capture, clear, then move
  always_ff @(posedge i_clk) begin
    if (!i_sys_rst) begin
      if (ind_wr) begin
        mem_r[ind_phys] <= i_reg_wdata;
      end else if (i_cap_wr) begin
        mem_r[disp_phys(i_cap_addr)] <= i_cap_wdata;
      end else if (clr_write) begin
        mem_r[disp_phys({1'b0, clr_idx_r})] <= CLEAR_BYTE;
      end else if (xd_grant && i_xd_wr && xd_hit) begin
        mem_r[xd_phys] <= i_xd_wdata;
      end
    end
  end

  // display reads are always served
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_disp_data  <= 8'h00;
      o_disp_valid <= 1'b0;
    end else begin
      o_disp_valid <= i_disp_rd;
      if (i_disp_rd) begin
        o_disp_data <= mem_r[disp_phys(i_disp_addr)];
      end
    end
  end

  // micro move read data
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_xd_rdata  <= 8'h00;
      o_xd_rvalid <= 1'b0;
    end else begin
      o_xd_rvalid <= xd_grant && i_xd_rd;
      if (xd_grant && i_xd_rd) begin
        o_xd_rdata <= xd_hit ? mem_r[xd_phys] : 8'h00;
      end
    end
  end

  // pointer advance
  logic [4:0] row_adv;
  logic [5:0] col_adv;
  always_comb begin
    row_adv = row_r;
    col_adv = col_r + 6'd1;
    if (row_r == LAST_ROW && col_r == LAST_COL_ROW25) begin
      row_adv = ROW_RST;
      col_adv = COL_RST;
    end else if (col_r == LAST_COL && row_r <= LAST_FULL_ROW) begin
      row_adv = row_r + 5'd1;
      col_adv = COL_RST;
    end
  end

  // pointers assume in-range loads by software
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      row_r <= ROW_RST;
      col_r <= COL_RST;
    end else if (ind_acc) begin
      row_r <= row_adv;
      col_r <= col_adv;
    end else begin
      if (ctl_wr) begin
        row_r <= i_reg_wdata[4:0];
      end
      if (i_reg_wr && i_reg_addr == COL_PTR_OFS) begin
        col_r <= i_reg_wdata[5:0];
      end
    end
  end

  // register read data, one cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        ROW_PTR_OFS:    o_reg_rdata <= {3'd0, row_r};
        COL_PTR_OFS:    o_reg_rdata <= {2'd0, col_r};
        IND_DATA_OFS:   o_reg_rdata <= mem_r[ind_phys];
        MEM_STATUS_OFS: begin
          o_reg_rdata <= {6'd0,
                          clr_state_r == CLR_WAIT_LINE,
                          o_page_clearing};
        end
        default:        o_reg_rdata <= 8'h00;
      endcase
    end else begin
      o_reg_rdata <= 8'h00;
    end
  end

endmodule // display_memory_interface

`default_nettype wire

// ===== src/display_memory_pkg.sv
// Purpose: constants for the shared display/auxiliary memory interface
// Assumes: 100 MHz system clock, byte-wide memory held in flip-flops
// Notes:   physical map: aux bytes first, display bytes after them
package display_memory_pkg;

  // clock and refresh timing
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          REFRESH_NS      = 15600;
  localparam int          REFRESH_CYCLES  = REFRESH_NS / CLK_PERIOD_NS;

  // physical memory layout
  localparam int          MEM_BYTES       = 2048;
  localparam int          PHYS_W          = 11;
  localparam logic [10:0] AUX_PHYS_BASE   = 11'h000;
  localparam logic [10:0] DISP_PHYS_BASE  = 11'h300;
  localparam int          PAGE_BYTES      = 1024;

  // microcontroller external data move address map
  localparam logic [15:0] AUX_LO          = 16'h0000;
  localparam logic [15:0] AUX_HI          = 16'h02FF;
  localparam logic [15:0] TEXT_LO         = 16'h2000;
  localparam logic [15:0] TEXT_HI         = 16'h24FF;
  localparam logic [15:0] CAPT_LO         = 16'h8000;
  localparam logic [15:0] CAPT_HI         = 16'h84FF;

  // fill value after power-up, reset and page clear
  localparam logic [7:0]  CLEAR_BYTE      = 8'h20;

  // indirect port register offsets
  localparam logic [3:0]  ROW_PTR_OFS     = 4'h0;
  localparam logic [3:0]  COL_PTR_OFS     = 4'h1;
  localparam logic [3:0]  IND_DATA_OFS    = 4'h2;
  localparam logic [3:0]  MEM_STATUS_OFS  = 4'h3;

  // field positions
  localparam int          CLEAR_MEM_BIT   = 7;
  localparam int          PAGE_CLR_BIT    = 0;
  localparam int          CLR_PEND_BIT    = 1;

  // text layout limits
  localparam logic [4:0]  LAST_FULL_ROW   = 5'd24;
  localparam logic [4:0]  LAST_ROW        = 5'd25;
  localparam logic [5:0]  LAST_COL        = 6'd39;
  localparam logic [5:0]  LAST_COL_ROW25  = 6'd23;
  localparam logic [5:0]  WIDE_COL        = 6'd32;
  localparam logic [9:0]  WIDE_BASE       = 10'h3F8;

  // reset values
  localparam logic [4:0]  ROW_RST         = 5'd0;
  localparam logic [5:0]  COL_RST         = 6'd0;
  localparam logic [9:0]  CLR_IDX_RST     = 10'd0;

  typedef enum logic [1:0] {
    CLR_IDLE,
    CLR_WAIT_LINE,
    CLR_RUN
  } clr_state_e;

endpackage

// ===== testbench/display_memory_checker.sv
// Purpose: port assertions for the display memory interface
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the design from the bench top
`timescale 1ns/1ps
`default_nettype none
module display_memory_checker
  import display_memory_pkg::*;
(
  // clock and reset
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  // register port
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // moves, display, status
  input wire logic       i_xd_rd,
  input wire logic       o_xd_wait,
  input wire logic       o_xd_rvalid,
  input wire logic       i_disp_rd,
  input wire logic       o_disp_valid,
  input wire logic       o_page_clearing
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_mv;
    i_xd_rd && !o_xd_wait;
  endsequence
  sequence s_clr;
    i_reg_wr && i_reg_addr == ROW_PTR_OFS && i_reg_wdata[CLEAR_MEM_BIT];
  endsequence
  property p_rdata; !i_reg_rd |=> o_reg_rdata == 8'h00; endproperty
  property p_mv; s_mv |=> o_xd_rvalid; endproperty
  property p_mv_q; !i_xd_rd || o_xd_wait |=> !o_xd_rvalid; endproperty
  property p_dsp; i_disp_rd |=> o_disp_valid; endproperty
  property p_clr; s_clr |=> o_page_clearing; endproperty
  property p_w_dsp; i_disp_rd && i_xd_rd |-> o_xd_wait; endproperty
  property p_w_ind;
    i_reg_rd && i_reg_addr == IND_DATA_OFS && i_xd_rd |-> o_xd_wait;
  endproperty
  property p_rst;
    disable iff (1'b0) i_sys_rst |=> o_page_clearing;
  endproperty
  a_rdata: assert property (p_rdata) else $error("stray reg data");
  a_mv: assert property (p_mv) else $error("move read lost");
  a_mv_q: assert property (p_mv_q) else $error("stray move valid");
  a_dsp: assert property (p_dsp) else $error("display read lost");
  a_clr: assert property (p_clr) else $error("clear flag late");
  a_w_dsp: assert property (p_w_dsp) else $error("move beat display");
  a_w_ind: assert property (p_w_ind) else $error("move beat port");
  a_rst: assert property (p_rst) else $error("no reset clear");
endmodule // display_memory_checker
`default_nettype wire

// ===== testbench/mcu_move_model.sv
// Purpose: microcontroller data-move master
// Assumes: request held until wait is seen low
// Notes:   released lines show the inverse value
`timescale 1ns/1ps
`default_nettype none
module mcu_move_model (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // command from the bench
  input  wire logic        i_go,
  input  wire logic        i_we,
  input  wire logic [15:0] i_a,
  input  wire logic [7:0]  i_d,
  // move port
  input  wire logic        i_wait,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [15:0] o_addr,
  output var  logic [7:0]  o_wdata,
  output wire logic        o_busy
);
  assign o_busy = o_wr | o_rd;
  initial {o_wr, o_rd, o_addr, o_wdata} = '0;
  always @(posedge i_clk) begin
    if (i_rst) begin
      {o_wr, o_rd} <= 2'h0;
    end else if (i_go) begin
      {o_wr, o_rd} <= {i_we, !i_we};
      o_addr <= i_a;
      o_wdata <= i_d;
    end else if (o_busy && !i_wait) begin
      {o_wr, o_rd} <= 2'h0;
      o_addr <= ~o_addr;
      o_wdata <= ~o_wdata;
    end
  end
endmodule // mcu_move_model
`default_nettype wire

// ===== testbench/display_memory_interface_tb.sv
// Purpose: self-checking bench for the display memory interface
// Assumes: moves issued through the partner model
// Notes:   one expectation queue per result port
`timescale 1ns/1ps
`default_nettype none
module display_memory_interface_tb import display_memory_pkg::*;;
  logic        i_clk, i_sys_rst, i_reg_wr, i_reg_rd, go, mwe, busy, rd_d;
  logic        i_disp_rd, i_cap_wr, i_cap_force_clear, i_line_start;
  logic        i_xd_wr, i_xd_rd, o_xd_wait, o_xd_rvalid, o_disp_valid;
  logic        o_page_clearing, o_refresh;
  int          last_ref = 0;
  logic [3:0]  i_reg_addr;
  logic [7:0]  i_reg_wdata, o_reg_rdata, o_xd_rdata, o_disp_data, md, ld;
  logic [7:0]  i_xd_wdata, i_cap_wdata, dv [8];
  logic [7:0]  q_reg [$], q_mv [$], q_dp [$];
  logic [10:0] i_disp_addr, i_cap_addr;
  logic [15:0] i_xd_addr, ma, la;
  int          n_errors = 0, n_compared = 0, cyc = 0;
  int          rr [8] = '{24, 24, 24, 24, 25, 25, 25, 0};
  int          cc [8] = '{36, 37, 38, 39, 0, 22, 23, 0};

  display_memory_interface dut_u (
    .i_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
    .o_reg_rdata, .i_xd_addr, .i_xd_wdata, .i_xd_wr, .i_xd_rd, .o_xd_wait,
    .o_xd_rdata, .o_xd_rvalid, .i_disp_rd, .i_disp_addr, .o_disp_data,
    .o_disp_valid, .i_cap_wr, .i_cap_addr, .i_cap_wdata, .i_cap_force_clear,
    .i_line_start, .o_page_clearing, .o_refresh);
  mcu_move_model mcu_u (.i_clk, .i_rst(i_sys_rst), .i_go(go), .i_we(mwe),
    .i_a(ma), .i_d(md), .i_wait(o_xd_wait), .o_wr(i_xd_wr), .o_rd(i_xd_rd),
    .o_addr(i_xd_addr), .o_wdata(i_xd_wdata), .o_busy(busy));

  function automatic logic [9:0] ofs(input int r, input int c);
    return (c < 32) ? 10'(r * 32 + c) : 10'(32'h3F8 - 8 * r + c - 32);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic rw(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} <= {wr, !wr, a, d};
    if (!wr) q_reg.push_back(d);
    @(posedge i_clk);
    {i_reg_wr, i_reg_rd} <= 2'h0;
  endtask
  task automatic mv(input logic we, input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {go, mwe, ma, md} <= {1'b1, we, a, d};
    if (!we) q_mv.push_back(d);
    @(posedge i_clk);
    go <= 1'b0;
    @(negedge i_clk);
    for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge i_clk);
  endtask
  task automatic dp(input logic [10:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {i_disp_rd, i_disp_addr} <= {1'b1, a};
    q_dp.push_back(d);
    @(posedge i_clk);
    i_disp_rd <= 1'b0;
  endtask
  task automatic ln(input logic f);
    @(posedge i_clk);
    {i_line_start, i_cap_force_clear} <= {1'b1, f};
    @(posedge i_clk);
    i_line_start <= 1'b0;
  endtask
  task automatic wclr();
    for (int k = 0; k < 3000 && o_page_clearing !== 1'b0; k++)
      @(negedge i_clk);
    check({7'h00, o_page_clearing}, 8'h00);
  endtask

  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      conclude();
    end
  end
  always @(negedge i_clk) begin
    if (rd_d) check(o_reg_rdata, q_reg.pop_front());
    if (o_xd_rvalid === 1'b1) check(o_xd_rdata, q_mv.pop_front());
    if (o_disp_valid === 1'b1) check(o_disp_data, q_dp.pop_front());
    rd_d = i_reg_rd;
    if (i_sys_rst) begin
      last_ref = 0;
    end else if (o_refresh === 1'b1) begin
      if (last_ref != 0)
        check({7'h00, cyc - last_ref == REFRESH_CYCLES}, 8'h01);
      last_ref = cyc;
    end
  end

  initial begin
    {i_clk, go, mwe, ma, md, rd_d, i_reg_wr, i_reg_rd, i_reg_addr} = '0;
    {i_reg_wdata, i_disp_rd, i_disp_addr, i_cap_wr, i_cap_addr} = '0;
    {i_cap_wdata, i_cap_force_clear, i_line_start} = '0;
    i_sys_rst = 1'b1;
    void'($urandom(87));
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    wclr();
    fork
      mv(1'b0, TEXT_LO, CLEAR_BYTE);
      begin
        @(posedge i_clk);
        rw(1'b0, IND_DATA_OFS, CLEAR_BYTE);
      end
    join
    fork
      mv(1'b0, CAPT_LO + 16'h03FF, CLEAR_BYTE);
      begin
        @(posedge i_clk);
        dp(11'h3FF, CLEAR_BYTE);
      end
    join
    $display("power-up fill done");
    rw(1'b1, ROW_PTR_OFS, 8'h18);
    rw(1'b1, COL_PTR_OFS, 8'h24);
    for (int i = 0; i < 8; i++) begin
      dv[i] = 8'($urandom);
      if (i == 5) rw(1'b1, COL_PTR_OFS, 8'h16);
      rw(1'b1, IND_DATA_OFS, dv[i]);
    end
    for (int i = 0; i < 8; i++)
      mv(1'b0, (i % 2 ? CAPT_LO : TEXT_LO) + 16'(ofs(rr[i], cc[i])), dv[i]);
    rw(1'b1, ROW_PTR_OFS, 8'h18);
    rw(1'b1, COL_PTR_OFS, 8'h24);
    rw(1'b0, IND_DATA_OFS, dv[0]);
    rw(1'b0, IND_DATA_OFS, dv[1]);
    $display("indirect port done");
    for (int i = 0; i < 4; i++) begin
      la = 16'($urandom % 768);
      ld = 8'($urandom);
      mv(1'b1, la, ld);
      mv(1'b0, la, ld);
    end
    mv(1'b1, 16'h4000, 8'h5A);
    mv(1'b0, 16'h4000, 8'h00);
    mv(1'b0, 16'h8500, 8'h00);
    @(posedge i_clk);
    {i_cap_wr, i_cap_addr, i_cap_wdata} <= {1'b1, 11'h410, 8'hA5};
    @(posedge i_clk);
    i_cap_wr <= 1'b0;
    mv(1'b0, 16'h2410, 8'hA5);
    dp(11'h410, 8'hA5);
    $display("map and capture done");
    mv(1'b1, 16'h2123, 8'h77);
    rw(1'b1, ROW_PTR_OFS, 8'h80);
    @(negedge i_clk);
    check({7'h00, o_page_clearing}, 8'h01);
    ln(1'b1);
    repeat (20) @(negedge i_clk);
    check({7'h00, o_page_clearing}, 8'h01);
    ln(1'b0);
    wclr();
    mv(1'b0, 16'h2123, CLEAR_BYTE);
    rw(1'b0, MEM_STATUS_OFS, 8'h00);
    $display("page clear done");
    mv(1'b1, TEXT_LO, 8'h3C);
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    wclr();
    mv(1'b0, TEXT_LO, CLEAR_BYTE);
    mv(1'b0, la, ld);
    $display("second reset done");
    conclude();
  end
endmodule // display_memory_interface_tb
bind display_memory_interface display_memory_checker chk_u (.i_clk,
  .i_sys_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
  .i_xd_rd, .o_xd_wait, .o_xd_rvalid, .i_disp_rd, .o_disp_valid,
  .o_page_clearing);
`default_nettype wire
